//--- hw/pdmc_regs.svh
`ifndef PDMC_REGS_SVH
`define PDMC_REGS_SVH
// Functional notes
// - Low-power instruction, standby and deep sleep select clear: enter sleep
// - Deep sleep select set: halt DMA, self-refresh
// - Standby select set: CPU, clock generator and all module clocks halt, self-refresh
// - Standby request pin low: halt, pins float
// - Status pins: HH reset, HL sleep, LH standby
// - Power-on or watchdog clears standby control
// - Hi-Z bit floats peripheral pins in standby
// - Port output pins ignore the hi-Z bit
// - Pull-up bit zero enables peripheral pull-ups
// - Stop bit four gates the DMA clock
// - Stop bit three gates FIFO serial clock
// - Stop bit two gates the timer clock
// - Stop bit one gates RTC interface only
// - Stop bit zero gates serial one clock
// - RTC counts whenever its run bit set
// - Clear register ones clear stop bits

// Register byte addresses
`define PDMC_ADR_CLK_STOP_SET 32'hfe0a0000
`define PDMC_ADR_CLK_STOP_CLR 32'hfe0a0008
`define PDMC_ADR_STANDBY_SELECT_CTL 32'hffc00004
`define PDMC_ADR_STANDBY_SELECT_CTL2 32'hffc00010

// Reset values
`define PDMC_RST_STANDBY_SELECT_CTL 8'h00
`define PDMC_RST_STANDBY_SELECT_CTL2 8'h00
`define PDMC_RST_CLK_STOP 32'h00000000

// Standby control fields
`define PDMC_STANDBY_SELECT 7
`define PDMC_PIN_HIZ_CONTROL 6
`define PDMC_PIN_PULLUP_CONTROL 5
`define PDMC_DMA_CLOCK_STOP 4
`define PDMC_SERIAL2_CLOCK_STOP 3
`define PDMC_TIMER_CLOCK_STOP 2
`define PDMC_RTC_CLOCK_STOP 1
`define PDMC_SERIAL1_CLOCK_STOP 0

// Standby control two fields
`define PDMC_DEEP_SLEEP_SELECT 7
`define PDMC_STANDBY_SELECT_CTL2_MASK 8'h80

// Clock-stop fields
`define PDMC_CSTP_TIMER34 1
`define PDMC_CSTP_INTC34 0
`define PDMC_CLK_STOP_MASK 32'h00000003

// Peripheral pin count and reset-state length
`define PDMC_PIN_N 8
`define PDMC_RESET_CYCLES 1
`endif

//--- hw/pdmc_pkg.sv
package pdmc_pkg;
    // Operating states, Gray along run to sleep to deep sleep to standby
    typedef enum logic [2:0] {
        st_reset = 3'h0,
        st_run = 3'h1,
        st_sleep = 3'h3,
        st_deep = 3'h2,
        st_standby_select = 3'h6,
        st_hwstby = 3'h7
    } pdmc_state_t;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pdmc_wb_req_t;

    // Clock enables toward the peripheral modules
    typedef struct packed {
        logic dma;
        logic serial2;
        logic timer;
        logic rtc_if;
        logic serial1;
        logic timer34;
        logic irq_timer34;
    } pdmc_clk_en_t;
endpackage

//--- hw/pdmc_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a pin level
module pdmc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic d,
    output logic q
);
    // First stage, read only by the second
    logic meta_r;

    // Both stages reset to the inactive level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // pdmc_sync

//--- hw/pdmc_ctrl.sv
`timescale 1ns/1ps
`include "pdmc_regs.svh"
// Power-down mode controller
module pdmc_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register bus
    input wire pdmc_pkg::pdmc_wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Processor events
    input wire logic sleep_exec,
    input wire logic wake_irq,
    input wire logic wdt_overflow,
    // Status and standby pins
    input wire logic hw_standby_request_n,
    output logic proc_state_upper,
    output logic proc_state_lower,
    output logic proc_state_oe,
    // Mode indications
    output logic cpu_halt,
    output logic clkgen_halt,
    output logic dma_halt,
    output logic ext_self_refresh,
    output logic pins_all_hiz,
    // Peripheral pin control
    input wire logic [`PDMC_PIN_N-1:0] pin_port_out,
    input wire logic [`PDMC_PIN_N-1:0] pin_is_input,
    output logic [`PDMC_PIN_N-1:0] pin_hiz_en,
    output logic [`PDMC_PIN_N-1:0] pin_pullup_en,
    // Module clocks
    output pdmc_pkg::pdmc_clk_en_t clk_en,
    input wire logic rtc_run_enable,
    output logic rtc_count_en
);
    // Byte-lane write mask from the select lines
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Status pin code for a state, upper bit first
    function automatic logic [1:0] status_code(
        input pdmc_pkg::pdmc_state_t st);
        case (st)
            pdmc_pkg::st_reset: status_code = 2'h3;
            pdmc_pkg::st_sleep,
            pdmc_pkg::st_deep: status_code = 2'h2;
            pdmc_pkg::st_standby_select,
            pdmc_pkg::st_hwstby: status_code = 2'h1;
            default: status_code = 2'h0;
        endcase
    endfunction

    // Synchronised standby request, low means enter
    logic hw_req_n_sync;
    // Mode state
    pdmc_pkg::pdmc_state_t state_r;
    pdmc_pkg::pdmc_state_t state_nxt;
    // Registers
    logic [7:0] standby_select_ctl_r;
    logic [7:0] standby_select_ctl2_r;
    logic [31:0] clk_stop_r;
    logic [31:0] clk_stop_nxt;
    // Bus handshake
    logic ack_r;
    logic ack_nxt;
    logic wr_en;
    logic [31:0] rd_nxt;
    logic [31:0] dat_r;
    // Registered outputs
    logic [1:0] status_r;
    logic status_oe_r;
    logic cpu_halt_r;
    logic clkgen_halt_r;
    logic dma_halt_r;
    logic self_ref_r;
    logic all_hiz_r;
    logic [`PDMC_PIN_N-1:0] hiz_r;
    logic [`PDMC_PIN_N-1:0] hiz_nxt;
    logic [`PDMC_PIN_N-1:0] pullup_r;
    pdmc_pkg::pdmc_clk_en_t clk_en_r;
    pdmc_pkg::pdmc_clk_en_t clk_en_nxt;
    logic rtc_cnt_r;
    // Peripherals alive in this state
    logic periph_on;

    // Pin level is asynchronous to sys_clk
    pdmc_sync #(.RST_VAL(1'b1)) u_hw_req_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(hw_standby_request_n),
        .q(hw_req_n_sync)
    );

    // Bus decode: single-cycle registered ack, unmapped reads as zero
    assign ack_nxt = wb_req.cyc & wb_req.stb & ~ack_r;
    assign wr_en = ack_nxt & wb_req.we;

    // Read mux; clear register is write-only and reads zero
    always_comb begin
        rd_nxt = 32'h00000000;
        case (wb_req.adr)
            `PDMC_ADR_CLK_STOP_SET: rd_nxt = clk_stop_r;
            `PDMC_ADR_STANDBY_SELECT_CTL: rd_nxt = {24'h000000, standby_select_ctl_r};
            `PDMC_ADR_STANDBY_SELECT_CTL2: rd_nxt = {24'h000000, standby_select_ctl2_r};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // Ack and read data register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= ack_nxt;
            if (ack_nxt && !wb_req.we) begin
                dat_r <= rd_nxt;
            end
        end
    end

    // Standby control registers; watchdog wins over a same-cycle write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby_select_ctl_r <= `PDMC_RST_STANDBY_SELECT_CTL;
            standby_select_ctl2_r <= `PDMC_RST_STANDBY_SELECT_CTL2;
        end else if (wdt_overflow && state_r != pdmc_pkg::st_hwstby) begin
            standby_select_ctl_r <= `PDMC_RST_STANDBY_SELECT_CTL;
            standby_select_ctl2_r <= `PDMC_RST_STANDBY_SELECT_CTL2;
        end else if (wr_en && wb_req.sel[0]) begin
            if (wb_req.adr == `PDMC_ADR_STANDBY_SELECT_CTL) begin
                standby_select_ctl_r <= wb_req.dat[7:0];
            end
            // Reserved bits stay zero
            if (wb_req.adr == `PDMC_ADR_STANDBY_SELECT_CTL2) begin
                standby_select_ctl2_r <= wb_req.dat[7:0] & `PDMC_STANDBY_SELECT_CTL2_MASK;
            end
        end
    end

    // Clock-stop: ones set through one address, clear through another
    always_comb begin
        clk_stop_nxt = clk_stop_r;
        if (wr_en && wb_req.adr == `PDMC_ADR_CLK_STOP_SET) begin
            clk_stop_nxt = clk_stop_r | (wb_req.dat
                & lane_mask(wb_req.sel) & `PDMC_CLK_STOP_MASK);
        end
        if (wr_en && wb_req.adr == `PDMC_ADR_CLK_STOP_CLR) begin
            clk_stop_nxt = clk_stop_r & ~(wb_req.dat
                & lane_mask(wb_req.sel));
        end
    end

    // Only power-on reset touches clock-stop, not the watchdog
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_stop_r <= `PDMC_RST_CLK_STOP;
        end else begin
            clk_stop_r <= clk_stop_nxt;
        end
    end

    // Mode sequencing; the pin outranks the watchdog, which outranks all
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pdmc_pkg::st_reset: begin
                state_nxt = pdmc_pkg::st_run;
            end
            pdmc_pkg::st_run: begin
                if (sleep_exec) begin
                    if (standby_select_ctl_r[`PDMC_STANDBY_SELECT]) begin
                        state_nxt = pdmc_pkg::st_standby_select;
                    end else if (standby_select_ctl2_r[`PDMC_DEEP_SLEEP_SELECT]) begin
                        state_nxt = pdmc_pkg::st_deep;
                    end else begin
                        state_nxt = pdmc_pkg::st_sleep;
                    end
                end
            end
            pdmc_pkg::st_sleep, pdmc_pkg::st_deep, pdmc_pkg::st_standby_select: begin
                if (wake_irq) begin
                    state_nxt = pdmc_pkg::st_run;
                end
            end
            pdmc_pkg::st_hwstby: begin
                state_nxt = pdmc_pkg::st_hwstby;
            end
            default: begin
                state_nxt = pdmc_pkg::st_reset;
            end
        endcase
        if (wdt_overflow && state_r != pdmc_pkg::st_hwstby) begin
            state_nxt = pdmc_pkg::st_reset;
        end
        if (!hw_req_n_sync) begin
            state_nxt = pdmc_pkg::st_hwstby;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= pdmc_pkg::st_reset;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Peripherals run in reset-exit, run, sleep and deep sleep
    assign periph_on = (state_nxt != pdmc_pkg::st_standby_select)
        && (state_nxt != pdmc_pkg::st_hwstby);

    // Module clock enables; a stop bit at zero lets a module resume
    always_comb begin
        clk_en_nxt.dma = periph_on && state_nxt != pdmc_pkg::st_deep
            && !standby_select_ctl_r[`PDMC_DMA_CLOCK_STOP];
        clk_en_nxt.serial2 = periph_on
            && !standby_select_ctl_r[`PDMC_SERIAL2_CLOCK_STOP];
        clk_en_nxt.timer = periph_on && !standby_select_ctl_r[`PDMC_TIMER_CLOCK_STOP];
        clk_en_nxt.rtc_if = periph_on && !standby_select_ctl_r[`PDMC_RTC_CLOCK_STOP];
        clk_en_nxt.serial1 = periph_on
            && !standby_select_ctl_r[`PDMC_SERIAL1_CLOCK_STOP];
        clk_en_nxt.timer34 = periph_on && !clk_stop_r[`PDMC_CSTP_TIMER34];
        clk_en_nxt.irq_timer34 = periph_on
            && !clk_stop_r[`PDMC_CSTP_INTC34];
    end

    // Peripheral pin float; port outputs keep driving under hi-Z bit
    always_comb begin
        hiz_nxt = '0;
        if (state_nxt == pdmc_pkg::st_hwstby) begin
            hiz_nxt = '1;
        end else if (state_nxt == pdmc_pkg::st_standby_select
            && standby_select_ctl_r[`PDMC_PIN_HIZ_CONTROL]) begin
            hiz_nxt = ~pin_port_out;
        end
    end

    // Pin control registers; pull-up setting is void in hw standby
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hiz_r <= '0;
            pullup_r <= '0;
        end else begin
            hiz_r <= hiz_nxt;
            if (state_nxt == pdmc_pkg::st_hwstby
                || standby_select_ctl_r[`PDMC_PIN_PULLUP_CONTROL]) begin
                pullup_r <= '0;
            end else begin
                pullup_r <= pin_is_input | hiz_nxt;
            end
        end
    end

    // Mode outputs follow the next state so they change with it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= 2'h3;
            status_oe_r <= 1'b1;
            cpu_halt_r <= 1'b0;
            clkgen_halt_r <= 1'b0;
            dma_halt_r <= 1'b0;
            self_ref_r <= 1'b0;
            all_hiz_r <= 1'b0;
            clk_en_r <= '1;
            rtc_cnt_r <= 1'b0;
        end else begin
            status_r <= status_code(state_nxt);
            // Status pins float in hw standby
            status_oe_r <= state_nxt != pdmc_pkg::st_hwstby;
            cpu_halt_r <= state_nxt != pdmc_pkg::st_run
                && state_nxt != pdmc_pkg::st_reset;
            clkgen_halt_r <= !periph_on;
            dma_halt_r <= !clk_en_nxt.dma;
            self_ref_r <= state_nxt == pdmc_pkg::st_deep
                || state_nxt == pdmc_pkg::st_standby_select;
            all_hiz_r <= state_nxt == pdmc_pkg::st_hwstby;
            clk_en_r <= clk_en_nxt;
            rtc_cnt_r <= rtc_run_enable;
        end
    end

    // Port drive
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign {proc_state_upper, proc_state_lower} = status_r;
    assign proc_state_oe = status_oe_r;
    assign cpu_halt = cpu_halt_r;
    assign clkgen_halt = clkgen_halt_r;
    assign dma_halt = dma_halt_r;
    assign ext_self_refresh = self_ref_r;
    assign pins_all_hiz = all_hiz_r;
    assign pin_hiz_en = hiz_r;
    assign pin_pullup_en = pullup_r;
    assign clk_en = clk_en_r;
    assign rtc_count_en = rtc_cnt_r;

    // Checks on the power-down behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // A clean instruction in run with no competing event
    sequence sleep_req_s;
        state_r == pdmc_pkg::st_run && sleep_exec && hw_req_n_sync
            && !wdt_overflow;
    endsequence

    sequence clr_write_s;
        wr_en && wb_req.adr == `PDMC_ADR_CLK_STOP_CLR
            && wb_req.sel[0] && wb_req.dat[`PDMC_CSTP_TIMER34];
    endsequence

    sleep_entry_a: assert property (
        sleep_req_s and (!standby_select_ctl_r[`PDMC_STANDBY_SELECT]
            && !standby_select_ctl2_r[`PDMC_DEEP_SLEEP_SELECT])
        |=> {proc_state_upper, proc_state_lower} == 2'h2 && cpu_halt
            && !clkgen_halt && !ext_self_refresh)
        else $error("sleep entry wrong");

    deep_entry_a: assert property (
        sleep_req_s and (!standby_select_ctl_r[`PDMC_STANDBY_SELECT]
            && standby_select_ctl2_r[`PDMC_DEEP_SLEEP_SELECT])
        |=> dma_halt && !clk_en.dma && ext_self_refresh && !clkgen_halt)
        else $error("deep sleep entry wrong");

    standby_entry_a: assert property (
        sleep_req_s and standby_select_ctl_r[`PDMC_STANDBY_SELECT]
        |=> clkgen_halt && cpu_halt && clk_en == '0
            && {proc_state_upper, proc_state_lower} == 2'h1)
        else $error("standby entry wrong");

    wake_exit_a: assert property (
        (state_r == pdmc_pkg::st_sleep || state_r == pdmc_pkg::st_deep
            || state_r == pdmc_pkg::st_standby_select) && wake_irq && hw_req_n_sync
            && !wdt_overflow
        |=> !cpu_halt && !clkgen_halt
            && {proc_state_upper, proc_state_lower} == 2'h0)
        else $error("wake did not return to run");

    hw_standby_a: assert property (
        !hw_req_n_sync |=> pins_all_hiz && !proc_state_oe && pin_hiz_en == '1
            ##1 state_r == pdmc_pkg::st_hwstby)
        else $error("hardware standby not held");

    wdt_status_a: assert property (
        wdt_overflow && hw_req_n_sync && state_r != pdmc_pkg::st_hwstby
        |=> {proc_state_upper, proc_state_lower} == 2'h3
            ##1 ({proc_state_upper, proc_state_lower} == 2'h0
                || !$past(hw_req_n_sync)))
        else $error("reset status code wrong");

    wdt_clear_a: assert property (
        wdt_overflow && state_r != pdmc_pkg::st_hwstby
        |=> standby_select_ctl_r == `PDMC_RST_STANDBY_SELECT_CTL && standby_select_ctl2_r == 8'h00)
        else $error("watchdog did not clear control");

    pin_hiz_a: assert property (
        !pins_all_hiz |-> (pin_hiz_en & $past(pin_port_out)) == '0)
        else $error("port output pin floated");

    standby_select_hiz_a: assert property (
        state_r == pdmc_pkg::st_standby_select && $past(state_r) == state_r
        |-> pin_hiz_en == ($past(standby_select_ctl_r[`PDMC_PIN_HIZ_CONTROL])
            ? ~$past(pin_port_out) : '0))
        else $error("standby pin float wrong");

    pullup_off_a: assert property (
        $past(standby_select_ctl_r[`PDMC_PIN_PULLUP_CONTROL]) |-> pin_pullup_en == '0)
        else $error("pull-up on while disabled");

    dma_stop_a: assert property (
        standby_select_ctl_r[`PDMC_DMA_CLOCK_STOP] |=> !clk_en.dma)
        else $error("DMA clock not stopped");

    clr_stop_a: assert property (
        clr_write_s |=> !clk_stop_r[`PDMC_CSTP_TIMER34] ##1 (clk_en.timer34
            || clkgen_halt))
        else $error("clock-stop clear failed");

    rtc_count_a: assert property (
        rtc_run_enable [*3] |-> rtc_count_en)
        else $error("RTC stopped while enabled");
endmodule // pdmc_ctrl

//--- test/pdmc_ext_sys.sv
`timescale 1ns/1ps
// External system on the status and standby pins
module pdmc_ext_sys (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Request from the bench
    input wire logic standby_select_cmd,
    // Status pins as driven by the device
    input wire logic proc_state_upper,
    input wire logic proc_state_lower,
    input wire logic proc_state_oe,
    // Standby request pin and board view of status
    output logic hw_standby_request_n,
    output logic [1:0] status_seen
);
    logic [1:0] last_r; // Last driven status, for the float pattern

    // standby pin drive
    // Pin stays high through reset, else the device falls back in
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_standby_request_n <= 1'b1;
        end else begin
            hw_standby_request_n <= !standby_select_cmd;
        end
    end

    // Floating pins keep no level: show the inverse of the last drive
    always_ff @(posedge sys_clk) begin
        if (proc_state_oe) begin
            last_r <= {proc_state_upper, proc_state_lower};
        end
    end

    assign status_seen = proc_state_oe ?
        {proc_state_upper, proc_state_lower} : ~last_r;
endmodule // pdmc_ext_sys

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "pdmc_regs.svh"
// Bench for the power-down mode controller
module tb_top;
    logic sys_clk = 1'b0; // 40 MHz system clock
    logic rst_n = 1'b0; // Power-on reset
    pdmc_pkg::pdmc_wb_req_t wb_req = '0; // Bus request
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic sleep_exec = 1'b0;
    logic wake_irq = 1'b0;
    logic wdt_overflow = 1'b0;
    logic standby_select_cmd = 1'b0; // Ask the far side to pull the pin low
    logic hw_standby_request_n;
    logic proc_state_upper, proc_state_lower, proc_state_oe;
    logic cpu_halt, clkgen_halt, dma_halt, ext_self_refresh, pins_all_hiz;
    logic [7:0] pin_port_out = 8'h03; // Two pins used as port outputs
    logic [7:0] pin_is_input = 8'h0c; // Two pins in input state
    logic [7:0] pin_hiz_en, pin_pullup_en;
    pdmc_pkg::pdmc_clk_en_t clk_en;
    logic rtc_run_enable = 1'b1; // RTC run bit, off in one test only
    logic rtc_count_en;
    logic [1:0] status_seen;
    logic [31:0] rd; // Data of the last read
    int mismatches = 0;
    int comparisons = 0;
    // Register map plus one unmapped place
    logic [31:0] adrs [5] = '{`PDMC_ADR_CLK_STOP_SET,
        `PDMC_ADR_CLK_STOP_CLR, `PDMC_ADR_STANDBY_SELECT_CTL,
        `PDMC_ADR_STANDBY_SELECT_CTL2, 32'hffc00008};

    // Clock generator
    always #12.5 sys_clk = ~sys_clk;

    pdmc_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_exec(sleep_exec),
        .wake_irq(wake_irq), .wdt_overflow(wdt_overflow),
        .hw_standby_request_n(hw_standby_request_n),
        .proc_state_upper(proc_state_upper),
        .proc_state_lower(proc_state_lower), .proc_state_oe(proc_state_oe),
        .cpu_halt(cpu_halt), .clkgen_halt(clkgen_halt), .dma_halt(dma_halt),
        .ext_self_refresh(ext_self_refresh), .pins_all_hiz(pins_all_hiz),
        .pin_port_out(pin_port_out), .pin_is_input(pin_is_input),
        .pin_hiz_en(pin_hiz_en), .pin_pullup_en(pin_pullup_en),
        .clk_en(clk_en), .rtc_run_enable(rtc_run_enable),
        .rtc_count_en(rtc_count_en));

    pdmc_ext_sys partner (.sys_clk(sys_clk), .rst_n(rst_n),
        .standby_select_cmd(standby_select_cmd), .proc_state_upper(proc_state_upper),
        .proc_state_lower(proc_state_lower), .proc_state_oe(proc_state_oe),
        .hw_standby_request_n(hw_standby_request_n),
        .status_seen(status_seen));

    // Compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            mismatches++;
        end
    endtask

    // Let edges pass, then step off the edge to sample
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        // No cycle count assumed; only the bench watchdog ends a hang
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_req <= '0;
        #1;
    endtask

    // One-cycle pulse of {sleep, wake, watchdog}
    task automatic ev(input logic [2:0] m);
        @(posedge sys_clk);
        {sleep_exec, wake_irq, wdt_overflow} <= m;
        @(posedge sys_clk);
        {sleep_exec, wake_irq, wdt_overflow} <= 3'h0;
        #1;
    endtask

    // Counts, verdict and end of run
    task automatic results();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        results();
    end

    // Main sequence
    initial begin
        tick(5);
        chk(status_seen, 2'b11);
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(2);
        chk(status_seen, 2'b00);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, adrs[i], 32'h0);
            chk(rd, 32'h0);
        end
        $display("reset test done");
        // no DMA transfer runs, none to halt or redo
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, `PDMC_ADR_STANDBY_SELECT_CTL, 32'h1 << i);
            wb(1'b0, `PDMC_ADR_STANDBY_SELECT_CTL, 32'h0);
            chk(rd, 32'h1 << i);
            tick(1);
            chk(clk_en, 7'h7f ^ (7'h04 << i));
            chk(dma_halt, i == 4);
            chk(rtc_count_en, 1'b1);
        end
        wb(1'b1, `PDMC_ADR_STANDBY_SELECT_CTL, 32'h0);
        tick(2);
        chk(clk_en, 7'h7f);
        $display("module stop test done");
        wb(1'b1, `PDMC_ADR_CLK_STOP_SET, 32'hffffffff);
        wb(1'b0, `PDMC_ADR_CLK_STOP_SET, 32'h0);
        chk(rd, 32'h3);
        chk(clk_en, 7'h7c);
        wb(1'b1, `PDMC_ADR_CLK_STOP_SET, 32'h0);
        wb(1'b1, `PDMC_ADR_CLK_STOP_CLR, 32'h1);
        wb(1'b0, `PDMC_ADR_CLK_STOP_SET, 32'h0);
        chk(rd, 32'h2);
        wb(1'b1, `PDMC_ADR_CLK_STOP_CLR, 32'h2);
        wb(1'b0, `PDMC_ADR_CLK_STOP_SET, 32'h0);
        chk(rd, 32'h0);
        $display("clock stop test done");
        chk(pin_pullup_en, 8'h0c);
        wb(1'b1, `PDMC_ADR_STANDBY_SELECT_CTL, 32'h60);
        tick(2);
        chk(pin_pullup_en, 8'h00);
        chk(pin_hiz_en, 8'h00);
        wb(1'b1, `PDMC_ADR_STANDBY_SELECT_CTL, 32'h0);
        $display("pull-up test done");
        ev(3'b100);
        chk(status_seen, 2'b10);
        chk({cpu_halt, clkgen_halt, ext_self_refresh}, 3'b100);
        chk(clk_en, 7'h7f);
        ev(3'b010);
        chk({status_seen, cpu_halt}, 3'b000);
        wb(1'b1, `PDMC_ADR_STANDBY_SELECT_CTL2, 32'h80);
        ev(3'b100);
        chk(status_seen, 2'b10);
        chk({dma_halt, ext_self_refresh, clkgen_halt}, 3'b110);
        ev(3'b010);
        chk({dma_halt, ext_self_refresh}, 2'b00);
        wb(1'b1, `PDMC_ADR_STANDBY_SELECT_CTL2, 32'h0);
        $display("sleep test done");
        wb(1'b1, `PDMC_ADR_STANDBY_SELECT_CTL, 32'hc0);
        ev(3'b100);
        chk(status_seen, 2'b01);
        chk({cpu_halt, clkgen_halt, ext_self_refresh}, 3'b111);
        chk(clk_en, 7'h00);
        chk(pin_hiz_en, 8'hfc);
        chk(pin_pullup_en, 8'hfc);
        chk(rtc_count_en, 1'b1);
        ev(3'b010);
        chk({status_seen, clkgen_halt}, 3'b000);
        chk(pin_hiz_en, 8'h00);
        $display("standby test done");
        // RTC count follows its run bit
        @(posedge sys_clk);
        rtc_run_enable <= 1'b0;
        tick(1);
        chk(rtc_count_en, 1'b0);
        @(posedge sys_clk);
        rtc_run_enable <= 1'b1;
        wb(1'b1, `PDMC_ADR_STANDBY_SELECT_CTL, 32'h1f);
        wb(1'b1, `PDMC_ADR_STANDBY_SELECT_CTL2, 32'h80);
        wb(1'b1, `PDMC_ADR_CLK_STOP_SET, 32'h1);
        ev(3'b001);
        chk(status_seen, 2'b11);
        tick(1);
        chk(status_seen, 2'b00);
        wb(1'b0, `PDMC_ADR_STANDBY_SELECT_CTL, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, `PDMC_ADR_STANDBY_SELECT_CTL2, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, `PDMC_ADR_CLK_STOP_SET, 32'h0);
        chk(rd, 32'h1);
        wb(1'b1, `PDMC_ADR_CLK_STOP_CLR, 32'h1);
        $display("watchdog test done");
        // hardware standby, left only by power-on reset
        @(posedge sys_clk);
        standby_select_cmd <= 1'b1;
        tick(6);
        chk({proc_state_oe, pins_all_hiz, cpu_halt}, 3'b011);
        ev(3'b010);
        chk({proc_state_oe, pins_all_hiz}, 2'b01);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        standby_select_cmd <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(3);
        chk({proc_state_oe, pins_all_hiz, status_seen}, 4'h8);
        $display("hardware standby test done");
        results();
    end
endmodule // tb_top
